/* File: design/bss_pkg.sv */
// shared constants and carrier types for the buck startup sequencer
package bss_pkg;
   localparam int CLK_HZ           = 20_000_000;
   localparam int HZ_PER_MHZ       = 1_000_000;
   localparam int CYCLES_PER_US    = CLK_HZ / HZ_PER_MHZ;
   localparam int ENABLE_ON_MV     = 1200;
   localparam int RAMP_UV_PER_US   = 400;
   localparam int SS_FINAL_MV      = 1500;
   localparam int SS_START_MV      = 150;
   localparam int SS_END_MV        = 750;
   localparam int STARTUP_US       = 1500;
   localparam int REF_W            = 12;
   localparam logic [REF_W-1:0] SS_FINAL =
      REF_W'(SS_FINAL_MV * 1000 / RAMP_UV_PER_US);
   localparam logic [REF_W-1:0] SS_WIN_LO =
      REF_W'(SS_START_MV * 1000 / RAMP_UV_PER_US);
   localparam logic [REF_W-1:0] SS_WIN_HI =
      REF_W'(SS_END_MV * 1000 / RAMP_UV_PER_US);
   localparam int US_CNT_W         = 5;
   localparam logic [US_CNT_W-1:0] US_LAST = US_CNT_W'(CYCLES_PER_US - 1);
   localparam int DUTY_STEPS       = 8;
   localparam int PULSES_PER_STEP  = 16;
   localparam logic [2:0] STEP_LAST  = 3'(DUTY_STEPS - 1);
   localparam logic [3:0] PULSE_LAST = 4'(PULSES_PER_STEP - 1);
   localparam int SW_PERIOD_DEF    = 32;
   localparam logic [REF_W-1:0] REF_RESET = '0;

   typedef enum logic [1:0] {
      BSS_LOCKOUT   = 2'b00,
      BSS_SOFTSTART = 2'b01,
      BSS_RUN       = 2'b11
   } bss_state_t;

   typedef struct packed {
      logic biasOk;
      logic enableOk;
      logic lightLoad;
      logic hsDemand;
   } bss_sense_t;

   typedef struct packed {
      logic hsGate;
      logic lsGate;
   } bss_drive_t;

   typedef struct packed {
      logic ocGuardEn;
      logic ovGuardEn;
      logic biasHigh;
   } bss_guard_t;
endpackage : bss_pkg

/* File: design/bss_ls_pulse.sv */
// switching period counter and low-side duty pulse shaper
`timescale 1ns/100ps
`default_nettype none
module bss_ls_pulse #(
   parameter int SW_PERIOD = bss_pkg::SW_PERIOD_DEF
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       clear,
   input  wire logic       armed,
   input  wire logic       steady,
   input  wire logic       hsOn,
   input  wire logic [2:0] step,
   output logic            lsOn,
   output logic            periodWrap
);
   import bss_pkg::*;

   localparam int PW = $clog2(SW_PERIOD);
   localparam int LW = PW + 1;
   localparam int EIGHTH = SW_PERIOD / DUTY_STEPS;

   initial begin
      if (SW_PERIOD < DUTY_STEPS || SW_PERIOD % DUTY_STEPS != 0)
         $error("SW_PERIOD must be a nonzero multiple of eight");
   end

   logic [PW-1:0] phase;
   logic [LW-1:0] lsLen;
   logic [LW-1:0] offPhase;
   wire           lastPhase = (phase == PW'(SW_PERIOD - 1));
   wire           offSat    = (offPhase == LW'(SW_PERIOD));
   wire           next_lsOn;

   // on-time grows by one eighth of the period per step; one spare bit
   // so that the last step (a full period) does not wrap to zero
   assign lsLen     = LW'((32'(step) + 32'd1) * EIGHTH);
   assign next_lsOn = armed && !hsOn && (steady || offPhase < lsLen);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase      <= '0;
         offPhase   <= '0;
         lsOn       <= 1'b0;
         periodWrap <= 1'b0;
      end else if (ce) begin
         phase      <= (clear || lastPhase) ? '0 : phase + 1'b1;
         // off-time counts only from the end of a high-side pulse and
         // saturates, so one low-side pulse per switching period
         offPhase   <= (clear || hsOn) ? '0 : (offSat ? offPhase : offPhase + 1'b1);
         lsOn       <= clear ? 1'b0 : next_lsOn;
         periodWrap <= lastPhase && !clear;
      end
   end
endmodule : bss_ls_pulse
`default_nettype wire

/* File: design/bss_sequencer.sv */
// lockout, soft-start ramp and pre-bias startup sequencing for the buck
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE1: drivers forced off while bias or enable low
// RULE2: leave lockout only when both inputs valid
// RULE3: raise supply-valid flag, then start soft-start
// RULE4: enable counts only above its 1.2V comparator
// RULE5: low side off until first high-side pulse
// RULE6: low-side on-time starts one eighth, steps eighths
// RULE7: sixteen pulses per step, eight steps total
// RULE8: reference ramps linearly zero to final value
// RULE9: startup window spans two reference points
// RULE10: current and voltage guards on during soft-start
// RULE11: light load selects low gate bias
// RULE12: lockout clears ramp and duty counters
module bss_sequencer #(
   parameter int SW_PERIOD = bss_pkg::SW_PERIOD_DEF
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     ce,
   input  wire bss_pkg::bss_sense_t      sense,
   output bss_pkg::bss_drive_t           drive,
   output bss_pkg::bss_guard_t           guard,
   output logic                          supplyValid,
   output logic                          softStartActive,
   output logic                          startupWindow,
   output logic                          dutyRampDone,
   output logic [bss_pkg::REF_W-1:0]     ssRef
);
   import bss_pkg::*;

   initial begin
      if (SW_PERIOD < DUTY_STEPS || SW_PERIOD % DUTY_STEPS != 0)
         $error("SW_PERIOD must be a nonzero multiple of eight");
   end

   bss_state_t              state;
   bss_state_t              next_state;
   logic [US_CNT_W-1:0]     usCnt;
   logic [2:0]              step;
   logic [3:0]              pulseCnt;
   logic                    firstHsSeen;
   logic                    steady;
   logic                    lsOn;
   logic                    periodWrap;

   // comparator outputs are already referred to their thresholds
   wire inputsValid = sense.biasOk && sense.enableOk; // RULE4
   wire lockNow     = !inputsValid;                   // RULE1
   wire running     = (state != BSS_LOCKOUT) && !lockNow;
   wire usTick      = (usCnt == US_LAST);
   wire rampTop     = (ssRef == SS_FINAL);
   wire hsOn        = running && sense.hsDemand;
   wire lsPulseEnd  = periodWrap && firstHsSeen && !steady;
   wire stepDone    = lsPulseEnd && (pulseCnt == PULSE_LAST);

   always_comb begin
      next_state = state;
      case (state)
         BSS_LOCKOUT: begin
            if (inputsValid)
               next_state = BSS_SOFTSTART; // RULE2 RULE3
         end
         BSS_SOFTSTART: begin
            if (lockNow)
               next_state = BSS_LOCKOUT;
            else if (rampTop && usTick)
               next_state = BSS_RUN;
         end
         BSS_RUN: begin
            if (lockNow)
               next_state = BSS_LOCKOUT;
         end
         default: next_state = BSS_LOCKOUT;
      endcase
   end

   bss_ls_pulse #(
      .SW_PERIOD (SW_PERIOD)
   ) u_ls_pulse (
      .clk        (clk),
      .rst        (rst),
      .ce         (ce),
      .clear      (!running),
      .armed      (firstHsSeen && running), // RULE5
      .steady     (steady),
      .hsOn       (hsOn),
      .step       (step),
      .lsOn       (lsOn),
      .periodWrap (periodWrap)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= BSS_LOCKOUT;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // soft-start reference, one step of 0.4 mV each microsecond
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         usCnt <= '0;
         ssRef <= REF_RESET;
      end else if (ce) begin
         if (!running) begin
            usCnt <= '0;         // RULE12
            ssRef <= REF_RESET;  // RULE12
         end else begin
            usCnt <= usTick ? '0 : usCnt + 1'b1;
            if (usTick && !rampTop)
               ssRef <= ssRef + 1'b1; // RULE8
         end
      end
   end

   // pre-bias duty stepping of the low-side switch
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         firstHsSeen <= 1'b0;
         step        <= '0;
         pulseCnt    <= '0;
         steady      <= 1'b0;
      end else if (ce) begin
         if (!running) begin
            firstHsSeen <= 1'b0; // RULE12
            step        <= '0;   // RULE12
            pulseCnt    <= '0;   // RULE12
            steady      <= 1'b0;
         end else begin
            if (hsOn)
               firstHsSeen <= 1'b1; // RULE5
            if (lsPulseEnd)
               pulseCnt <= pulseCnt + 1'b1; // RULE7
            if (stepDone) begin
               if (step == STEP_LAST)
                  steady <= 1'b1; // RULE6
               else
                  step <= step + 1'b1; // RULE6
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drive           <= '0;
         guard           <= '0;
         supplyValid     <= 1'b0;
         softStartActive <= 1'b0;
         startupWindow   <= 1'b0;
         dutyRampDone    <= 1'b0;
      end else if (ce) begin
         drive.hsGate    <= hsOn;                  // RULE1
         drive.lsGate    <= lsOn && running;       // RULE1 RULE5
         supplyValid     <= inputsValid;           // RULE3
         softStartActive <= running && (state == BSS_SOFTSTART);
         startupWindow   <= running && ssRef >= SS_WIN_LO
                            && ssRef < SS_WIN_HI;  // RULE9
         dutyRampDone    <= running && steady;
         guard.ocGuardEn <= running;               // RULE10
         guard.ovGuardEn <= running;               // RULE10
         guard.biasHigh  <= !sense.lightLoad;      // RULE11
      end
   end
endmodule : bss_sequencer
`default_nettype wire

/* File: dv/bss_sequencer_monitor.sv */
// port checker for the startup sequencer
`timescale 1ns/100ps
`default_nettype none
module bss_sequencer_monitor #(
   parameter int SW_PERIOD = bss_pkg::SW_PERIOD_DEF
) (
   input wire logic                      clk,
   input wire logic                      rst,
   input wire logic                      ce,
   input wire bss_pkg::bss_sense_t       sense,
   input wire bss_pkg::bss_drive_t       drive,
   input wire bss_pkg::bss_guard_t       guard,
   input wire logic                      supplyValid,
   input wire logic                      softStartActive,
   input wire logic                      startupWindow,
   input wire logic                      dutyRampDone,
   input wire logic [bss_pkg::REF_W-1:0] ssRef
);
   import bss_pkg::*;
   logic seenHs;
   wire  ok    = sense.biasOk && sense.enableOk;
   wire  inWin = ssRef >= SS_WIN_LO && ssRef < SS_WIN_HI;
   always_ff @(posedge clk or posedge rst)
      if (rst) seenHs <= 1'b0;
      else if (ce) seenHs <= ok && (seenHs || drive.hsGate);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_held; ce && $stable(ssRef); endsequence
   sequence s_rise; $rose(supplyValid) && ok; endsequence
   property p_lockOff; ce && !ok |=> drive == '0; endproperty
   a_lockOff: assert property (p_lockOff) else $error("gates on in lockout");
   property p_flag; ce |=> supplyValid == $past(ok); endproperty
   a_flag: assert property (p_flag) else $error("supply flag wrong");
   property p_go; s_rise ##1 ce |-> softStartActive; endproperty
   a_go: assert property (p_go) else $error("ramp not started");
   property p_guard; softStartActive |-> guard.ocGuardEn && guard.ovGuardEn; endproperty
   a_guard: assert property (p_guard) else $error("guard off in ramp");
   property p_step; softStartActive && $changed(ssRef) && ssRef != '0
      |-> ssRef == $past(ssRef) + 1'b1; endproperty
   a_step: assert property (p_step) else $error("ramp step not one");
   property p_hold; $changed(ssRef) |=> ($stable(ssRef) || ssRef == '0) [*8]; endproperty
   a_hold: assert property (p_hold) else $error("ramp too fast");
   property p_win; s_held ##1 s_held |-> startupWindow == inWin; endproperty
   a_win: assert property (p_win) else $error("window flag wrong");
   property p_lsFirst; drive.lsGate |-> seenHs; endproperty
   a_lsFirst: assert property (p_lsFirst) else $error("low side early");
   property p_bias; ce && ok && softStartActive
      |=> guard.biasHigh == !$past(sense.lightLoad); endproperty
   a_bias: assert property (p_bias) else $error("bias level wrong");
   property p_clear; $fell(supplyValid) |-> ##[0:1] (ssRef == '0 && !dutyRampDone); endproperty
   a_clear: assert property (p_clear) else $error("counters kept");
endmodule : bss_sequencer_monitor
`default_nettype wire

/* File: dv/bss_pwm_model.sv */
// pwm stand-in: periodic high-side requests while running
`timescale 1ns/100ps
`default_nettype none
module bss_pwm_model #(
   parameter int PERIOD = 8
) (
   input  wire logic clk,
   input  wire logic run,
   output logic      hsDemand = 1'b0
);
   int ph = 0;
   always @(posedge clk) begin
      ph <= run ? (ph + 1) % PERIOD : 0;
      hsDemand <= run && ph < 2;
   end
endmodule : bss_pwm_model
`default_nettype wire

/* File: dv/tb_bss_sequencer.sv */
// self-checking bench for the startup sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_bss_sequencer;
   import bss_pkg::*;
   localparam int SWP = 8;
   logic             clk = 0, rst = 1, ce = 1, run = 0, bias = 0, en = 0, light = 0;
   logic             hsDemand, supplyValid, softStartActive, startupWindow, dutyRampDone;
   bss_drive_t       drive;
   bss_guard_t       guard;
   logic [REF_W-1:0] ssRef;
   int               errTotal = 0, checks = 0, cyc = 0;
   wire bss_sense_t  sense = {bias, en, light, hsDemand};
   bss_sequencer #(.SW_PERIOD(SWP)) i_bss_sequencer (.clk, .rst, .ce, .sense, .drive,
      .guard, .supplyValid, .softStartActive, .startupWindow, .dutyRampDone, .ssRef);
   bss_pwm_model #(.PERIOD(SWP)) i_bss_pwm_model (.clk, .run, .hsDemand);
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errTotal++;
         test_done();
      end
   end
   task tick(input int n); repeat (n) @(posedge clk); #1; endtask : tick
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         errTotal++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task t_lockout;
      for (int i = 0; i < 2; i++) begin
         @(posedge clk); bias <= i[0]; en <= !i[0]; run <= 1;
         tick(40);
         chk(drive, 16'h0);
         chk(supplyValid, 16'h0);
         chk(softStartActive, 16'h0);
      end
      $display("lockout done");
   endtask : t_lockout
   task t_start;
      int n;
      @(posedge clk); run <= 0; bias <= 1; en <= 1; light <= 1;
      tick(3);
      chk(supplyValid, 16'h1);
      chk(softStartActive, 16'h1);
      chk(guard, 16'h6);
      n = 0;
      repeat (20) begin tick(1); n += drive.lsGate; end
      chk(16'(n), 16'h0);
      @(posedge clk); run <= 1;
      n = 0;
      while (drive.hsGate !== 1'b1 && n < 50) begin tick(1); n++; end
      chk(drive.hsGate, 16'h1);
      n = 0;
      repeat (64) begin tick(1); n += drive.lsGate; end
      chk(16'(n), 16'(64 / SWP));
      n = 64;
      while (dutyRampDone !== 1'b1 && n < 2000) begin tick(1); n++; end
      chk(16'(n / SWP >= 127 && n / SWP <= 129), 16'h1);
      n = 0;
      repeat (64) begin tick(1); n += drive.lsGate; end
      chk(16'(n), 16'(64 - 16));
      $display("start done");
   endtask : t_start
   task t_ramp;
      logic [REF_W-1:0] r;
      int n;
      r = ssRef;
      n = 0;
      while (ssRef === r && n < 30) begin tick(1); n++; end
      r = ssRef;
      tick(CYCLES_PER_US);
      chk(ssRef, r + 1'b1);
      @(posedge clk); ce <= 0; light <= 0;
      tick(60);
      chk(ssRef, r + 1'b1);
      @(posedge clk); ce <= 1;
      tick(2);
      chk(guard.biasHigh, 16'h1);
      chk(startupWindow, 16'h0);
      n = 0;
      while (startupWindow !== 1'b1 && n < 9000) begin tick(1); n++; end
      chk(ssRef, SS_WIN_LO);
      $display("ramp done");
   endtask : t_ramp
   task t_restart;
      @(posedge clk); en <= 0;
      tick(2);
      chk(drive, 16'h0);
      chk(ssRef, 16'h0);
      chk(dutyRampDone, 16'h0);
      $display("restart done");
   endtask : t_restart
   task test_done;
      $display("checks=%0d errors=%0d", checks, errTotal);
      if (errTotal == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      t_lockout();
      t_start();
      t_ramp();
      t_restart();
      t_start();
      test_done();
   end
endmodule : tb_bss_sequencer
bind bss_sequencer bss_sequencer_monitor #(.SW_PERIOD(SW_PERIOD)) i_bss_sequencer_monitor (
   .clk, .rst, .ce, .sense, .drive, .guard, .supplyValid, .softStartActive,
   .startupWindow, .dutyRampDone, .ssRef);
`default_nettype wire
